// ==== design/mtt_top.sv ====
// melody tone timer: tone divider, 4-bit timer, register port, pin
// assumes prescaler taps are asynchronous levels and a plain reg port
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/10ps
module mtt_top
    import mtt_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // register port
    input wire logic [3:0] reg_addr_in,
    input wire logic [3:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [3:0] reg_rdata_out,
    // prescaler taps
    input wire logic [7:0] prescaler_tap_in,
    // buzzer pin
    output logic tone_pin_out,
    output logic tone_pin_oe_out,
    // interrupt request line
    output logic tone_timer_irq_out
);

    ////////////////////////////////////////////////////////////////////////
    // declarations
    logic tone_pin_tristate_reg;
    logic [2:0] tone_code_reg;
    logic sw_tone_switch_reg;
    logic auto_reg;
    logic [1:0] timer_tap_select_reg;
    logic [3:0] period_reg;
    logic [3:0] count_reg;
    logic tail_reg;
    logic tone_timer_irq_reg;
    logic tone_timer_irq_mask_reg;
    logic [7:0] tap_meta_reg;
    logic [7:0] tap_sync_reg;
    logic tap_prev_reg;
    logic [3:0] rdata_reg;
    logic pin_reg;
    logic oe_reg;
    mtt_state_e state_reg;

    logic wr_freq;
    logic wr_ctrl;
    logic wr_period;
    logic wr_flags;
    logic wr_mask;
    logic tap_level;
    logic tick;
    logic hold_last;
    logic zero_evt;
    logic auto_start;
    logic timer_active;
    logic sounding;

    mtt_tone_if tone_bus ();

    ////////////////////////////////////////////////////////////////////////
    // write decode
    assign wr_freq = reg_wr_in && reg_addr_in == MTT_OFS_FREQ;
    assign wr_ctrl = reg_wr_in && reg_addr_in == MTT_OFS_CTRL;
    assign wr_period = reg_wr_in && reg_addr_in == MTT_OFS_PERIOD;
    assign wr_flags = reg_wr_in && reg_addr_in == MTT_OFS_FLAGS;
    assign wr_mask = reg_wr_in && reg_addr_in == MTT_OFS_MASK;

    // frequency select and pin tristate bit
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            tone_pin_tristate_reg <= MTT_RST_TRISTATE;
            tone_code_reg <= MTT_RST_CODE;
        end else if (wr_freq) begin
            tone_pin_tristate_reg <= reg_wdata_in[MTT_BIT_TRISTATE];
            tone_code_reg <= reg_wdata_in[2:0];
        end
    end

    // timer control: switch, auto bit, tap select
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            sw_tone_switch_reg <= 1'b0;
            auto_reg <= 1'b0;
            timer_tap_select_reg <= MTT_RST_TAP_SEL;
        end else if (wr_period && reg_wdata_in == 4'h0) begin
            auto_reg <= 1'b0;
        end else if (wr_ctrl) begin
            sw_tone_switch_reg <= reg_wdata_in[MTT_BIT_SWITCH];
            auto_reg <= reg_wdata_in[MTT_BIT_AUTO];
            timer_tap_select_reg <= reg_wdata_in[1:0];
        end
    end

    // period holding register, write only from software
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            period_reg <= MTT_RST_PERIOD;
        end else if (wr_period) begin
            period_reg <= reg_wdata_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // two-flop synchroniser on every tap; the taps come from elsewhere
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            tap_meta_reg <= 8'h00;
            tap_sync_reg <= 8'h00;
        end else begin
            tap_meta_reg <= prescaler_tap_in;
            tap_sync_reg <= tap_meta_reg;
        end
    end

    // tap multiplexer; switching it mid-run may give a stray edge
    always_comb begin
        tap_level = 1'b0;
        unique case (timer_tap_select_reg)
            2'h0: tap_level = tap_sync_reg[MTT_TAP_SEL0];
            2'h1: tap_level = tap_sync_reg[MTT_TAP_SEL1];
            2'h2: tap_level = tap_sync_reg[MTT_TAP_SEL2];
            2'h3: tap_level = tap_sync_reg[MTT_TAP_SEL3];
        endcase
    end

    // rising edge of the chosen tap is the only timer advance
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            tap_prev_reg <= 1'b0;
        end else begin
            tap_prev_reg <= tap_level;
        end
    end

    assign tick = tap_level && !tap_prev_reg;

    ////////////////////////////////////////////////////////////////////////
    // timer events
    // after auto falls mid-run the last period gets one extra tick
    assign hold_last = tail_reg && !auto_reg;
    assign zero_evt = tick && state_reg == MTT_RUN && count_reg == 4'h1
        && !hold_last && !wr_period;
    assign auto_start = wr_ctrl && reg_wdata_in[MTT_BIT_AUTO] && !auto_reg
        && period_reg != 4'h0 && state_reg != MTT_RUN;

    // timer state, count and the tail marker
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_reg <= MTT_IDLE;
            count_reg <= 4'h0;
            tail_reg <= 1'b0;
        end else if (wr_period && reg_wdata_in == 4'h0) begin
            state_reg <= MTT_IDLE;
            count_reg <= 4'h0;
            tail_reg <= 1'b0;
        end else if (wr_period) begin
            if (state_reg == MTT_IDLE) begin
                state_reg <= MTT_ARMED;
            end
        end else if (auto_start) begin
            state_reg <= MTT_RUN;
            count_reg <= period_reg;
            tail_reg <= 1'b0;
        end else begin
            if (wr_ctrl && auto_reg && !reg_wdata_in[MTT_BIT_AUTO]
                && state_reg == MTT_RUN) begin
                tail_reg <= 1'b1;
            end
            unique case (state_reg)
                MTT_IDLE: begin
                    count_reg <= 4'h0;
                end
                MTT_ARMED: begin
                    if (tick) begin
                        state_reg <= MTT_RUN;
                        count_reg <= period_reg;
                    end
                end
                MTT_RUN: begin
                    if (tick && count_reg == 4'h1 && hold_last) begin
                        tail_reg <= 1'b0;
                    end else if (tick && count_reg == 4'h1) begin
                        if (auto_reg) begin
                            count_reg <= period_reg;
                        end else begin
                            count_reg <= 4'h0;
                            state_reg <= MTT_IDLE;
                            tail_reg <= 1'b0;
                        end
                    end else if (tick) begin
                        count_reg <= count_reg - 4'h1;
                    end
                end
                // unused code: fall back to idle rather than hang
                default: begin
                    state_reg <= MTT_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // request flag: set wins over a clear written in the same cycle
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            tone_timer_irq_reg <= 1'b0;
        end else if (zero_evt) begin
            tone_timer_irq_reg <= 1'b1;
        end else if (wr_flags && reg_wdata_in[MTT_BIT_IRQ]) begin
            tone_timer_irq_reg <= 1'b0;
        end
    end

    // mask bit: 1 lets the request reach the line
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            tone_timer_irq_mask_reg <= 1'b0;
        end else if (wr_mask) begin
            tone_timer_irq_mask_reg <= reg_wdata_in[MTT_BIT_IRQ];
        end
    end

    assign tone_timer_irq_out = tone_timer_irq_reg
        && tone_timer_irq_mask_reg;

    ////////////////////////////////////////////////////////////////////////
    // tone generation; silence still lets the timer run
    assign timer_active = state_reg == MTT_RUN && count_reg != 4'h0;
    assign sounding = timer_active || sw_tone_switch_reg;
    assign tone_bus.tone_code = tone_code_reg;
    assign tone_bus.enable = sounding;

    mtt_tone_div u_tone_div (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .tone(tone_bus.gen)
    );

    // pin level and enable registered; idle pin level is zero
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            pin_reg <= 1'b0;
            oe_reg <= 1'b0;
        end else begin
            pin_reg <= sounding && tone_bus.wave;
            oe_reg <= !tone_pin_tristate_reg;
        end
    end

    assign tone_pin_out = pin_reg;
    assign tone_pin_oe_out = oe_reg;

    ////////////////////////////////////////////////////////////////////////
    // read data stands in the cycle after the strobe only
    always_ff @(posedge clk_in) begin
        if (srst_in || !reg_rd_in) begin
            rdata_reg <= 4'h0;
        end else begin
            unique case (reg_addr_in)
                MTT_OFS_FREQ: rdata_reg <= {tone_pin_tristate_reg,
                    tone_code_reg};
                MTT_OFS_CTRL: rdata_reg <= {sounding, auto_reg,
                    timer_tap_select_reg};
                MTT_OFS_FLAGS: rdata_reg <= {3'h0, tone_timer_irq_reg};
                MTT_OFS_MASK: rdata_reg <= {3'h0, tone_timer_irq_mask_reg};
                MTT_OFS_COUNT: rdata_reg <= count_reg;
                default: rdata_reg <= 4'h0;
            endcase
        end
    end

    assign reg_rdata_out = rdata_reg;

endmodule

// ==== pkg/mtt_pkg.sv ====
// constants, register map and tone table for the melody tone timer
// assumes a single system clock; the prescaler taps arrive as levels
package mtt_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register offsets on the plain register port
    localparam logic [3:0] MTT_OFS_FREQ = 4'h0;
    localparam logic [3:0] MTT_OFS_CTRL = 4'h1;
    localparam logic [3:0] MTT_OFS_PERIOD = 4'h2;
    localparam logic [3:0] MTT_OFS_FLAGS = 4'h3;
    localparam logic [3:0] MTT_OFS_MASK = 4'h4;
    localparam logic [3:0] MTT_OFS_COUNT = 4'h5;

    // field positions
    localparam int MTT_BIT_TRISTATE = 3;
    localparam int MTT_BIT_SWITCH = 3;
    localparam int MTT_BIT_AUTO = 2;
    localparam int MTT_BIT_IRQ = 0;

    // values after reset
    localparam logic MTT_RST_TRISTATE = 1'b1;
    localparam logic [2:0] MTT_RST_CODE = 3'h0;
    localparam logic [1:0] MTT_RST_TAP_SEL = 2'h0;
    localparam logic [3:0] MTT_RST_PERIOD = 4'h0;

    // tap index on the prescaler bus for each select code
    localparam logic [2:0] MTT_TAP_SEL0 = 3'h3;
    localparam logic [2:0] MTT_TAP_SEL1 = 3'h5;
    localparam logic [2:0] MTT_TAP_SEL2 = 3'h7;
    localparam logic [2:0] MTT_TAP_SEL3 = 3'h1;

    // timer states, gray along idle, armed, running
    typedef enum logic [1:0] {
        MTT_IDLE = 2'b00,
        MTT_ARMED = 2'b01,
        MTT_RUN = 2'b11
    } mtt_state_e;

    // half period in system clocks for each tone code, zero means silence
    function automatic logic [3:0] mtt_half_period(input logic [2:0] code);
        logic [3:0] h;
        h = 4'h0;
        unique case (code)
            3'h0: h = 4'h0;
            3'h1: h = 4'h4;
            3'h2: h = 4'h5;
            3'h3: h = 4'h6;
            3'h4: h = 4'h7;
            3'h5: h = 4'h8;
            3'h6: h = 4'hA;
            3'h7: h = 4'hC;
        endcase
        return h;
    endfunction

endpackage

// ==== pkg/mtt_tone_if.sv ====
// carrier between the timer core and the tone divider
// assumes both ends sit on the same system clock
`timescale 1ns/10ps
interface mtt_tone_if;
    logic [2:0] tone_code;
    logic enable;
    logic wave;

    modport ctl (output tone_code, output enable, input wave);
    modport gen (input tone_code, input enable, output wave);
endinterface

// ==== design/mtt_tone_div.sv ====
// tone divider: 50% square wave at the system clock over 8 .. 24
// assumes clk_in is the system clock and srst_in is synchronous
`timescale 1ns/10ps
module mtt_tone_div
    import mtt_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // tone carrier
    mtt_tone_if.gen tone
);

    logic [3:0] cnt_reg;
    logic [3:0] half;
    logic wave_reg;

    ////////////////////////////////////////////////////////////////////////
    // half period lookup; wave toggles each half so duty stays even
    assign half = mtt_half_period(tone.tone_code);

    // divider counter restarts when idle so each burst begins low
    always_ff @(posedge clk_in) begin
        if (srst_in || !tone.enable || half == 4'h0) begin
            cnt_reg <= 4'h0;
            wave_reg <= 1'b0;
        end else if (cnt_reg == half - 4'h1) begin
            cnt_reg <= 4'h0;
            wave_reg <= ~wave_reg;
        end else begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end

    assign tone.wave = wave_reg;

endmodule

// ==== test/mtt_top_properties.sv ====
// port assertions for the melody tone timer
// assumes it is bound into mtt_top, one clock, sync reset
`timescale 1ns/10ps
module mtt_top_properties
    import mtt_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // register port
    input wire logic [3:0] reg_addr_in,
    input wire logic [3:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [3:0] reg_rdata_out,
    // taps, pin and request
    input wire logic [7:0] prescaler_tap_in,
    input wire logic tone_pin_out,
    input wire logic tone_pin_oe_out,
    input wire logic tone_timer_irq_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (srst_in);

    logic wr_freq;
    logic wr_ctrl;
    logic [2:0] code_reg;
    logic sw_reg;

    assign wr_freq = reg_wr_in && reg_addr_in == MTT_OFS_FREQ;
    assign wr_ctrl = reg_wr_in && reg_addr_in == MTT_OFS_CTRL;

    // shadows of code and switch; the switch is write-only on the port
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            code_reg <= 3'h0;
            sw_reg <= 1'b0;
        end else begin
            if (wr_freq)
                code_reg <= reg_wdata_in[2:0];
            if (wr_ctrl)
                sw_reg <= reg_wdata_in[MTT_BIT_SWITCH];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // a rise long after the switch came on is a wave edge, not a start
    sequence s_rise_code1;
        sw_reg && $past(sw_reg, 8) && code_reg == 3'h1 && $rose(tone_pin_out);
    endsequence
    sequence s_hold_code1;
        (sw_reg && code_reg == 3'h1)[*4];
    endsequence
    sequence s_zero_period;
        reg_wr_in && reg_addr_in == MTT_OFS_PERIOD && reg_wdata_in == 4'h0
            && !sw_reg;
    endsequence

    a_half_period_four: assert property (
        s_rise_code1 ##0 s_hold_code1 |-> $past(tone_pin_out) ##1 !tone_pin_out)
        else $error("tone half period is not four clocks");
    // the enable lags the write by two clocks: bit register, then pin flop
    a_oe_from_write: assert property (
        wr_freq |-> ##2
        tone_pin_oe_out != $past(reg_wdata_in[MTT_BIT_TRISTATE], 2))
        else $error("pin enable does not follow tristate bit");
    a_oe_holds_still: assert property (
        !wr_freq && !$past(wr_freq) |=> $stable(tone_pin_oe_out))
        else $error("pin enable moved without a write");
    a_reset_floats_pin: assert property ($fell(srst_in) |->
        !tone_pin_oe_out && !tone_pin_out && !tone_timer_irq_out)
        else $error("pin or request active after reset");
    a_mask_blocks_irq: assert property (
        reg_wr_in && reg_addr_in == MTT_OFS_MASK && !reg_wdata_in[0]
        |=> !tone_timer_irq_out)
        else $error("masked request still on the line");
    a_zero_period_quiet: assert property (
        s_zero_period |=> (!$rose(tone_timer_irq_out))[*4])
        else $error("zero period raised a request");
    a_zero_period_mute: assert property (
        s_zero_period |-> ##2 (!tone_pin_out)[*3])
        else $error("pin sounds after zero period");
    a_silence_holds_low: assert property (
        (code_reg == 3'h0)[*4] |-> !tone_pin_out)
        else $error("silence code drives the pin high");
endmodule

bind mtt_top mtt_top_properties i_props (.clk_in(clk_in),
    .srst_in(srst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .prescaler_tap_in(prescaler_tap_in), .tone_pin_out(tone_pin_out),
    .tone_pin_oe_out(tone_pin_oe_out),
    .tone_timer_irq_out(tone_timer_irq_out));

// ==== test/mtt_buzzer_model.sv ====
// buzzer on the pin: measures high runs and counts rises
// assumes one clock; a floated pin makes no sound
`timescale 1ns/10ps
module mtt_buzzer_model (
    // clock
    input wire logic clk_in,
    // pin as seen by the buzzer
    input wire logic pin_in,
    input wire logic oe_in,
    // measurements
    output logic [7:0] half_out,
    output logic [7:0] rises_out
);
    logic sound;
    logic last_reg = 1'b0;
    logic [7:0] run_reg = 8'h00;
    logic [7:0] half_reg = 8'h00;
    logic [7:0] rise_reg = 8'h00;

    assign sound = oe_in && pin_in;
    assign half_out = half_reg;
    assign rises_out = rise_reg;

    // last finished high run is the half period; partial runs get
    // overwritten, so the bench waits a few tone periods first
    always @(posedge clk_in) begin
        last_reg <= sound;
        if (sound)
            run_reg <= run_reg + 8'h01;
        else
            run_reg <= 8'h00;
        if (last_reg && !sound)
            half_reg <= run_reg;
        if (sound && !last_reg)
            rise_reg <= rise_reg + 8'h01;
    end
endmodule

// ==== test/tb_melody_tone_timer.sv ====
// self-checking bench for the melody tone timer
// assumes package, checker and buzzer model are compiled first
`timescale 1ns/10ps
module tb_melody_tone_timer;
    import mtt_pkg::*;

    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [3:0] wdata = 4'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] tap = 8'h00;
    logic [3:0] rdata;
    logic pin;
    logic oe;
    logic irq;
    logic [7:0] half;
    logic [7:0] rises;
    logic [7:0] rises0;
    int fails = 0;
    int compares = 0;
    logic [2:0] tap_idx [4] = '{3'h3, 3'h5, 3'h7, 3'h1};
    logic [7:0] half_exp [8] = '{8'h00, 8'h04, 8'h05, 8'h06, 8'h07,
        8'h08, 8'h0A, 8'h0C};

    mtt_top i_dut (.clk_in(clk_in), .srst_in(srst_in),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_rdata_out(rdata), .prescaler_tap_in(tap),
        .tone_pin_out(pin), .tone_pin_oe_out(oe),
        .tone_timer_irq_out(irq));
    mtt_buzzer_model i_buzzer (.clk_in(clk_in), .pin_in(pin), .oe_in(oe),
        .half_out(half), .rises_out(rises));

    // free-running system clock
    initial begin
        forever #5 clk_in = ~clk_in;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [3:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe edge
    task automatic rd_chk(input logic [3:0] a, input logic [3:0] exp);
        @(posedge clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        #1;
        chk({4'h0, rdata}, {4'h0, exp});
    endtask

    // tap pulse long enough to pass the synchroniser
    task automatic tick(input int s);
        @(posedge clk_in);
        tap[tap_idx[s]] <= 1'b1;
        repeat (6) @(posedge clk_in);
        tap[tap_idx[s]] <= 1'b0;
        repeat (6) @(posedge clk_in);
    endtask

    task automatic end_of_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // watchdog, far beyond the expected run length
    initial begin
        repeat (20000) @(posedge clk_in);
        fails++;
        end_of_test();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk_in);
        srst_in <= 1'b0;
        chk({6'h00, oe, pin}, 8'h00);
        rd_chk(MTT_OFS_FREQ, 4'h8);
        rd_chk(MTT_OFS_CTRL, 4'h0);
        rd_chk(MTT_OFS_PERIOD, 4'h0);
        wr_reg(4'hF, 4'hF);
        rd_chk(MTT_OFS_FREQ, 4'h8);
        // tone codes 1 to 7 under the software switch
        wr_reg(MTT_OFS_FREQ, 4'h1);
        repeat (2) @(posedge clk_in);
        chk({7'h00, oe}, 8'h01);
        wr_reg(MTT_OFS_CTRL, 4'h8);
        rd_chk(MTT_OFS_CTRL, 4'h8);
        for (int c = 1; c < 8; c++) begin
            wr_reg(MTT_OFS_FREQ, 4'(c));
            repeat (80) @(posedge clk_in);
            chk(half, half_exp[c]);
        end
        wr_reg(MTT_OFS_FREQ, 4'hF);
        repeat (2) @(posedge clk_in);
        chk({7'h00, oe}, 8'h00);
        wr_reg(MTT_OFS_CTRL, 4'h0);
        repeat (4) @(posedge clk_in);
        chk({7'h00, pin}, 8'h00);
        rd_chk(MTT_OFS_CTRL, 4'h0);
        // each tap, silent tone, wrong tap ignored, mask toggled
        wr_reg(MTT_OFS_FREQ, 4'h0);
        rises0 = rises;
        for (int s = 0; s < 4; s++) begin
            wr_reg(MTT_OFS_MASK, {3'h0, s[0]});
            wr_reg(MTT_OFS_CTRL, 4'(s));
            wr_reg(MTT_OFS_PERIOD, 4'h1);
            tick((s + 1) % 4);
            tick(s);
            rd_chk(MTT_OFS_FLAGS, 4'h0);
            tick(s);
            rd_chk(MTT_OFS_FLAGS, 4'h1);
            chk({7'h00, irq}, {7'h00, s[0]});
            wr_reg(MTT_OFS_FLAGS, 4'h1);
            rd_chk(MTT_OFS_FLAGS, 4'h0);
        end
        chk(rises, rises0);
        // single run, period three
        wr_reg(MTT_OFS_MASK, 4'h1);
        wr_reg(MTT_OFS_FREQ, 4'h1);
        wr_reg(MTT_OFS_CTRL, 4'h0);
        wr_reg(MTT_OFS_PERIOD, 4'h3);
        rises0 = rises;
        rd_chk(MTT_OFS_CTRL, 4'h0);
        chk(rises, rises0);
        tick(0);
        rd_chk(MTT_OFS_CTRL, 4'h8);
        rd_chk(MTT_OFS_COUNT, 4'h3);
        tick(0);
        tick(0);
        rd_chk(MTT_OFS_COUNT, 4'h1);
        chk({7'h00, rises != rises0}, 8'h01);
        tick(0);
        chk({7'h00, irq}, 8'h01);
        rd_chk(MTT_OFS_CTRL, 4'h0);
        wr_reg(MTT_OFS_FLAGS, 4'h1);
        // continuous run, then back to single run
        wr_reg(MTT_OFS_CTRL, 4'h1);
        wr_reg(MTT_OFS_PERIOD, 4'h2);
        wr_reg(MTT_OFS_CTRL, 4'h5);
        rd_chk(MTT_OFS_COUNT, 4'h2);
        rd_chk(MTT_OFS_CTRL, 4'hD);
        tick(1);
        tick(1);
        rd_chk(MTT_OFS_FLAGS, 4'h1);
        rd_chk(MTT_OFS_COUNT, 4'h2);
        wr_reg(MTT_OFS_FLAGS, 4'h1);
        wr_reg(MTT_OFS_CTRL, 4'h1);
        tick(1);
        tick(1);
        rd_chk(MTT_OFS_CTRL, 4'h9);
        tick(1);
        rd_chk(MTT_OFS_CTRL, 4'h1);
        rd_chk(MTT_OFS_FLAGS, 4'h1);
        wr_reg(MTT_OFS_FLAGS, 4'h1);
        // zero period stops a continuous run with no request
        wr_reg(MTT_OFS_CTRL, 4'h5);
        tick(1);
        wr_reg(MTT_OFS_PERIOD, 4'h0);
        rd_chk(MTT_OFS_CTRL, 4'h1);
        rd_chk(MTT_OFS_COUNT, 4'h0);
        tick(1);
        tick(1);
        tick(1);
        rd_chk(MTT_OFS_FLAGS, 4'h0);
        end_of_test();
    end
endmodule
